//--- irq_arb_pkg.sv
// Constants and types shared by the two-level interrupt arbiter
package irq_arb_pkg;
  localparam int NUM_SRC = 19;
  localparam int FLAGS_PER_SRC = 4;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] LAST_IDX = 5'h12;
  localparam logic [IDX_W-1:0] HW_CLEAR_LIMIT = 5'h04;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int GLOBAL_EN_BIT = 31;
  localparam int STAT_LO_BIT = 0;
  localparam int STAT_HI_BIT = 1;
  localparam int STAT_CALL_BIT = 2;
  localparam int STAT_RETI_BIT = 3;
  localparam int STAT_IDX_LSB = 8;
  localparam int STAT_VEC_LSB = 16;

  // Reset values
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] LEVEL_RST = 32'h0000_0000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;

  // Cycle counts
  localparam int CALL_CYCLES = 5;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

  typedef enum logic {ST_IDLE, ST_CALL} arb_state_e;

  typedef struct packed {
    logic valid;
    logic level;
    logic [IDX_W-1:0] index;
    logic [15:0] vector;
  } call_s;
endpackage

//--- two_level_interrupt_arbiter.sv
// Two-level interrupt arbiter with vectoring and an APB register slave
module two_level_interrupt_arbiter #(
  parameter int NUM_SRC = irq_arb_pkg::NUM_SRC,
  parameter int FLAGS_PER_SRC = irq_arb_pkg::FLAGS_PER_SRC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [NUM_SRC*FLAGS_PER_SRC-1:0] pendFlags, // Pending flags per source
  input wire logic instrDone, // CPU finished an instruction
  input wire logic retiDone, // CPU finished a return from interrupt
  output irq_arb_pkg::call_s callOut, // Vector call request to CPU
  output logic callStart, // Call accepted this cycle
  output logic [3:0] hwClear // Flag clear pulses for sources 0 to 3
);
  logic [31:0] enableReg_r, enableReg_nxt;
  logic [31:0] levelReg_r, levelReg_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [NUM_SRC-1:0] srcActive;
  logic [NUM_SRC-1:0] reqSample_r, reqSample_nxt;
  irq_arb_pkg::arb_state_e state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic inSvcLo_r, inSvcLo_nxt;
  logic inSvcHi_r, inSvcHi_nxt;
  logic afterReti_r, afterReti_nxt;
  irq_arb_pkg::call_s call_r, call_nxt;
  logic [3:0] hwClear_r, hwClear_nxt;
  logic [NUM_SRC-1:0] reqHi, reqLo;
  logic anyHi, anyLo, pickLevel, pickValid, canAccept;
  logic [irq_arb_pkg::IDX_W-1:0] idxHi, idxLo, pickIdx;
  logic globalEn;
  logic wrEn, setup, mapped;

  // Lowest set index wins
  function automatic logic [irq_arb_pkg::IDX_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
    logic [irq_arb_pkg::IDX_W-1:0] r;
    r = irq_arb_pkg::LAST_IDX;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = irq_arb_pkg::IDX_W'(i);
      end
    end
    return r;
  endfunction

  assign globalEn = enableReg_r[irq_arb_pkg::GLOBAL_EN_BIT];

  // Flags themselves are never touched here, so masked ones stay pending
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    assign srcActive[s] = (|pendFlags[s*FLAGS_PER_SRC +: FLAGS_PER_SRC])
      && enableReg_r[s] && globalEn;
  end

  // APB slave, zero wait states; read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite && mapped;
  always_comb begin
    mapped = 1'b0;
    if (paddr == irq_arb_pkg::OFS_ENABLE) begin
      mapped = 1'b1;
    end else if (paddr == irq_arb_pkg::OFS_LEVEL) begin
      mapped = 1'b1;
    end else if (paddr == irq_arb_pkg::OFS_STATUS) begin
      mapped = 1'b1;
    end
  end

  always_comb begin
    logic [31:0] srcMask;
    logic [31:0] status;
    // Only the implemented source bits, plus bit 31 of the enable register, are writable; other upper bits read as zero
    srcMask = 32'({NUM_SRC{1'b1}});
    status = 32'h0000_0000;
    status[irq_arb_pkg::STAT_LO_BIT] = inSvcLo_r;
    status[irq_arb_pkg::STAT_HI_BIT] = inSvcHi_r;
    status[irq_arb_pkg::STAT_CALL_BIT] = call_r.valid;
    status[irq_arb_pkg::STAT_RETI_BIT] = afterReti_r;
    status[irq_arb_pkg::STAT_IDX_LSB +: irq_arb_pkg::IDX_W] = call_r.index;
    status[irq_arb_pkg::STAT_VEC_LSB +: 16] = call_r.vector;
    enableReg_nxt = enableReg_r;
    levelReg_nxt = levelReg_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pslverr_nxt = !mapped;
      if (paddr == irq_arb_pkg::OFS_ENABLE) begin
        prdata_nxt = enableReg_r;
      end else if (paddr == irq_arb_pkg::OFS_LEVEL) begin
        prdata_nxt = levelReg_r;
      end else if (paddr == irq_arb_pkg::OFS_STATUS) begin
        prdata_nxt = status;
      end else begin
        prdata_nxt = 32'h0000_0000;
      end
    end
    if (wrEn && paddr == irq_arb_pkg::OFS_ENABLE) begin
      enableReg_nxt = pwdata & (srcMask | 32'h8000_0000);
    end else if (wrEn && paddr == irq_arb_pkg::OFS_LEVEL) begin
      levelReg_nxt = pwdata & srcMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enableReg_r <= irq_arb_pkg::ENABLE_RST;
      levelReg_r <= irq_arb_pkg::LEVEL_RST;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      enableReg_r <= enableReg_nxt;
      levelReg_r <= levelReg_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1;

  // Priority decode on the sampled requests
  assign reqHi = reqSample_r & levelReg_r[NUM_SRC-1:0];
  assign reqLo = reqSample_r & ~levelReg_r[NUM_SRC-1:0];
  assign anyHi = |reqHi;
  assign anyLo = |reqLo;
  assign idxHi = lowest(reqHi);
  assign idxLo = lowest(reqLo);
  always_comb begin
    pickValid = 1'b0;
    pickLevel = 1'b0;
    pickIdx = idxLo;
    if (anyHi && !inSvcHi_r) begin
      pickValid = 1'b1;
      pickLevel = 1'b1;
      pickIdx = idxHi;
    end else if (anyLo && !inSvcHi_r && !inSvcLo_r) begin
      pickValid = 1'b1;
    end
  end

  // Instruction right after a return must finish before the next call
  assign canAccept = (state_r == irq_arb_pkg::ST_IDLE) && instrDone && !afterReti_r;
  assign callStart = canAccept && pickValid;

  always_comb begin
    reqSample_nxt = srcActive;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    inSvcLo_nxt = inSvcLo_r;
    inSvcHi_nxt = inSvcHi_r;
    afterReti_nxt = afterReti_r;
    call_nxt = call_r;
    hwClear_nxt = 4'h0;
    if (retiDone) begin
      afterReti_nxt = 1'b1;
    end else if (instrDone) begin
      afterReti_nxt = 1'b0;
    end
    case (state_r)
      irq_arb_pkg::ST_IDLE: begin
        if (retiDone) begin
          if (inSvcHi_r) begin
            inSvcHi_nxt = 1'b0;
          end else begin
            inSvcLo_nxt = 1'b0;
          end
        end
        if (callStart) begin
          state_nxt = irq_arb_pkg::ST_CALL;
          cnt_nxt = irq_arb_pkg::CALL_LAST;
          call_nxt.valid = 1'b1;
          call_nxt.level = pickLevel;
          call_nxt.index = pickIdx;
          call_nxt.vector = irq_arb_pkg::VEC_BASE + {8'h00, pickIdx, 3'h0};
          if (pickIdx < irq_arb_pkg::HW_CLEAR_LIMIT) begin
            hwClear_nxt = 4'(4'h1 << pickIdx[1:0]);
          end
        end
      end
      irq_arb_pkg::ST_CALL: begin
        if (cnt_r == 3'h0) begin
          state_nxt = irq_arb_pkg::ST_IDLE;
          call_nxt.valid = 1'b0;
          if (call_r.level) begin
            inSvcHi_nxt = 1'b1;
          end else begin
            inSvcLo_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: begin
        state_nxt = irq_arb_pkg::ST_IDLE;
      end
    endcase
  end

  // Reset itself outranks every source: it forces the reset vector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reqSample_r <= '0;
      state_r <= irq_arb_pkg::ST_IDLE;
      cnt_r <= 3'h0;
      inSvcLo_r <= 1'b0;
      inSvcHi_r <= 1'b0;
      afterReti_r <= 1'b0;
      call_r <= '{valid: 1'b0, level: 1'b0, index: '0, vector: irq_arb_pkg::RESET_VECTOR};
      hwClear_r <= 4'h0;
    end else begin
      reqSample_r <= reqSample_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      inSvcLo_r <= inSvcLo_nxt;
      inSvcHi_r <= inSvcHi_nxt;
      afterReti_r <= afterReti_nxt;
      call_r <= call_nxt;
      hwClear_r <= hwClear_nxt;
    end
  end

  assign callOut = call_r;
  assign hwClear = hwClear_r;

  // Checks
  chk_reset_level: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> levelReg_r == 32'h0000_0000)
    else $error("levels not low after reset");

  chk_hi_no_preempt: assert property (@(posedge clk) disable iff (!rst_n)
    inSvcHi_r |-> !callStart)
    else $error("call accepted while high routine in service");

  chk_lo_hold_off: assert property (@(posedge clk) disable iff (!rst_n)
    (inSvcLo_r && callStart) |-> pickLevel && anyHi)
    else $error("low request entered over low routine");

  chk_call_length: assert property (@(posedge clk) disable iff (!rst_n)
    callStart |=> callOut.valid [*5] ##1 !callOut.valid)
    else $error("vector call not five cycles");

  chk_hw_clear: assert property (@(posedge clk) disable iff (!rst_n)
    callStart |=> ((hwClear != 4'h0) == ($past(pickIdx) < irq_arb_pkg::HW_CLEAR_LIMIT)))
    else $error("hardware clear on wrong source");

  chk_after_return: assert property (@(posedge clk) disable iff (!rst_n)
    retiDone ##1 instrDone |-> !callStart)
    else $error("call before instruction following return");

  chk_vector_map: assert property (@(posedge clk) disable iff (!rst_n)
    callOut.valid |-> callOut.vector == 16'h0003 + {8'h00, callOut.index, 3'h0})
    else $error("vector address mismatch");

  chk_global_mask: assert property (@(posedge clk) disable iff (!rst_n)
    !globalEn |=> reqSample_r == '0)
    else $error("request raised with global enable clear");

  chk_high_first: assert property (@(posedge clk) disable iff (!rst_n)
    (callStart && anyHi) |=> callOut.level && callOut.index == $past(idxHi))
    else $error("high level request not served first");

  chk_nest_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (retiDone && inSvcHi_r && state_r == irq_arb_pkg::ST_IDLE)
      |=> !inSvcHi_r && inSvcLo_r == $past(inSvcLo_r))
    else $error("return did not restore preempted level");

  chk_entry_level: assert property (@(posedge clk) disable iff (!rst_n)
    (callOut.valid && cnt_r == 3'h0 && callOut.level) |=> inSvcHi_r)
    else $error("high level not recorded in service");
endmodule

//--- cpu_model.sv
// CPU sequencer and peripheral flag model facing the arbiter
module cpu_model (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] gap, // Idle cycles between instructions
  input wire logic retiReq, // Next completion is a return
  input wire logic [75:0] setMask, // Flags raised by peripherals
  input wire logic [75:0] clrMask, // Flags cleared by software
  input wire logic [3:0] hwClear, // Hardware clear pulses
  output logic instrDone, // Instruction finished
  output logic retiDone, // Return finished
  output logic [75:0] pendFlags // Pending flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic retiPend_r;
  logic [75:0] hwMask;
  always_comb begin
    hwMask = '0;
    for (int s = 0; s < 4; s++) begin
      if (hwClear[s]) begin
        hwMask[4*s +: 4] = 4'hf;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      retiPend_r <= 1'b0;
      instrDone <= 1'b0;
      retiDone <= 1'b0;
      pendFlags <= '0;
    end else begin
      cnt_r <= (cnt_r >= gap) ? 4'h0 : cnt_r + 4'h1;
      instrDone <= (cnt_r >= gap) && !(retiPend_r || retiReq);
      retiDone <= (cnt_r >= gap) && (retiPend_r || retiReq);
      retiPend_r <= (retiPend_r || retiReq) && !(cnt_r >= gap);
      // Flags stay set until software or a hardware pulse clears them
      pendFlags <= (pendFlags | setMask) & ~clrMask & ~hwMask;
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench for the two-level interrupt arbiter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [75:0] pendFlags, setMask = '0, clrMask = '0;
  logic instrDone, retiDone, retiReq = 0, callStart, er;
  logic [3:0] gap = 4'h2, hwClear;
  irq_arb_pkg::call_s callOut;
  int err_count = 0, comparisons = 0, cycles = 0, skips;
  always #5 clk = ~clk;
  two_level_interrupt_arbiter u_two_level_interrupt_arbiter (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pendFlags(pendFlags),
    .instrDone(instrDone), .retiDone(retiDone), .callOut(callOut), .callStart(callStart),
    .hwClear(hwClear));
  cpu_model u_cpu_model (.clk(clk), .rst_n(rst_n), .gap(gap), .retiReq(retiReq),
    .setMask(setMask), .clrMask(clrMask), .hwClear(hwClear), .instrDone(instrDone),
    .retiDone(retiDone), .pendFlags(pendFlags));
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task pulse(input logic [75:0] m, input logic clr);
    @(posedge clk);
    if (clr) clrMask <= m; else setMask <= m;
    @(posedge clk);
    clrMask <= '0; setMask <= '0;
  endtask
  task reti;
    int n;
    n = 0;
    @(posedge clk);
    retiReq <= 1'b1;
    @(posedge clk);
    retiReq <= 1'b0;
    while (retiDone !== 1'b1 && n < 40) begin @(posedge clk); n++; end
    check(32'(n < 40), 1, "no return");
  endtask
  task quiet(input int n);
    logic seen;
    seen = 0;
    repeat (n) begin @(posedge clk); #1 seen |= callStart; end
    check(32'(seen), 0, "call while held off");
  endtask
  task waitCall(input logic [4:0] idx, input logic lvl);
    int n;
    n = 0; skips = 0;
    @(posedge clk); #1;
    while (callStart !== 1'b1 && n < 300) begin
      if (instrDone === 1'b1) skips++;
      @(posedge clk); #1 n++;
    end
    check(32'(n < 300), 1, "no call");
    @(posedge clk); #1;
    check({callOut.valid, callOut.level, callOut.index}, {1'b1, lvl, idx}, "call fields");
    check(32'(callOut.vector), 32'(16'h0003 + 16'(idx) * 16'h0008), "vector");
    check(32'(hwClear), (idx < 4) ? 32'(1) << idx : 0, "hw clear");
    repeat (4) @(posedge clk);
    #1 check(32'(callOut.valid), 1, "call short");
    @(posedge clk);
    #1 check(32'(callOut.valid), 0, "call long");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check(32'(callOut.vector), 0, "reset vector");
    apb(0, irq_arb_pkg::OFS_LEVEL, 0);
    check(rd, 0, "level reset");
    apb(1, irq_arb_pkg::OFS_LEVEL, 32'h0007ffff);
    apb(0, irq_arb_pkg::OFS_LEVEL, 0);
    check(rd, 32'h0007ffff, "level bits");
    apb(1, irq_arb_pkg::OFS_LEVEL, 0);
    apb(0, 8'h0c, 0);
    check(32'(er), 1, "unmapped");
    $display("register test done");
    // Flag raised while globally masked must wait
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h00000020);
    pulse(76'h1 << 20, 0);
    quiet(30);
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h80000020);
    waitCall(5'd5, 0);
    reti;
    waitCall(5'd5, 0);
    check(skips, 1, "one instruction after return");
    pulse(76'hf << 20, 1);
    reti;
    $display("mask test done");
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h80000084);
    apb(1, irq_arb_pkg::OFS_LEVEL, 32'h00000080);
    pulse((76'h1 << 8) | (76'h1 << 28), 0);
    waitCall(5'd7, 1);
    quiet(20);
    pulse(76'hf << 28, 1);
    reti;
    waitCall(5'd2, 0);
    pulse(76'h1 << 29, 0);
    waitCall(5'd7, 1);
    apb(0, irq_arb_pkg::OFS_STATUS, 0);
    check(32'(rd[1:0]), 3, "both levels in service");
    pulse(76'hf << 28, 1);
    reti;
    apb(0, irq_arb_pkg::OFS_STATUS, 0);
    check(32'(rd[1:0]), 1, "low resumed");
    reti;
    $display("preempt test done");
    gap <= 4'h7;
    apb(1, irq_arb_pkg::OFS_LEVEL, 0);
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h80040084);
    pulse((76'h1 << 8) | (76'h1 << 28) | (76'h8 << 72), 0);
    waitCall(5'd2, 0);
    quiet(20);
    reti;
    waitCall(5'd7, 0);
    check(skips, 1, "slow instruction skipped");
    pulse(76'hf << 28, 1);
    reti;
    waitCall(5'd18, 0);
    $display("order test done");
    // Read-only flag: software stops re-entry through the source enable
    pulse(76'hf << 72, 1);
    reti;
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h80008000);
    pulse(76'h1 << 60, 0);
    waitCall(5'd15, 0);
    apb(1, irq_arb_pkg::OFS_ENABLE, 32'h80000000);
    reti;
    quiet(40);
    $display("enable stop test done");
    close_out;
  end
endmodule
